// [verilog/lufc_pkg.sv]
/*
 * Constants, field positions and types of the serial channel control-one window:
 * receive noise filter configuration and bus node (master/slave) control.
 * Assumes a single 40 MHz clock and APB register access with 32-bit data.
 */
// How it works
// - mode select 001b routes the control-one address to the noise filter configuration.
// - filter enable bit 7 low bypasses the filter, high sends all receive data through it.
// - filter width field bits 6:4 picks a 4-bit (000) up to 11-bit (111) up/down counter.
// - a wider counter rejects longer noise pulses and adds a longer delay.
// - mode select 010b routes the same address to the bus node control register.
// - master bit 7 gives master operation only if multiprocessor, parity and slave are off.
// - slave bit 6 gives slave operation only if multiprocessor, parity and master are off.
// - rate detect enable bit 5 turns on baud measurement only in slave operation.
// - with bit 4 set in slave mode, the measured character sets the done flag, which interrupts only when its mask bit 0 is set.
// - node state 00 sleep, 01 wait for break, 10 baud measurement, 11 active; hw advances.
// - in master mode the break length field gives 13 (00) up to 16 (11) bit times of break.
package lufc_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_MODE = 12'hF40;
  localparam logic [11:0] IDX_CFG  = 12'hF41;
  localparam logic [11:0] IDX_CTL1 = 12'hF43;
  localparam logic [11:0] IDX_STAT = 12'hF44;
  localparam logic [11:0] IDX_MASK = 12'hF45;
  localparam logic [11:0] IDX_RATE = 12'hF46;

  localparam logic [2:0] MODE_SELECT_FIELD_FILTER = 3'h1;
  localparam logic [2:0] MODE_SELECT_FIELD_NODE   = 3'h2;

  localparam int FILT_EN_BIT = 7;
  localparam int FILT_W_LSB  = 4;
  localparam int MST_BIT     = 7;
  localparam int SLV_BIT     = 6;
  localparam int RDE_BIT     = 5;
  localparam int RDIE_BIT    = 4;
  localparam int STATE_LSB   = 2;
  localparam int CFG_MULTIPROCESSOR_ENABLE    = 0;
  localparam int CFG_PEN     = 1;
  localparam int CFG_SENDBRK = 2;

  localparam int ST_RATE_DONE = 0;
  localparam int ST_BRK_RX    = 1;
  localparam int ST_BRK_TX    = 2;

  localparam logic [7:0] CTL_RESET  = 8'h00;
  localparam logic [2:0] STAT_RESET = 3'h0;
  localparam int FILT_MAX_W = 11;

  localparam int CLK_MHZ     = 40;
  localparam int BIT_TIME_NS = 52083;
  localparam int BIT_CYCLES  = (BIT_TIME_NS * CLK_MHZ) / 1000;
  localparam int RX_BREAK_BITS  = 11;
  localparam int TX_BREAK_BASE  = 13;
  localparam int SYNC_FALLS     = 5;

  typedef enum logic [1:0] {
    NODE_SLEEP    = 2'h0,
    NODE_WAIT_BRK = 2'h1,
    NODE_RATE     = 2'h2,
    NODE_ACTIVE   = 2'h3
  } lufc_node_e;
endpackage

// [verilog/lufc_filt_if.sv]
/*
 * Signals between the control logic and the receive noise filter.
 * Assumes rx_in is already synchronised to the one system clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface lufc_filt_if;
  logic       enable;
  logic [2:0] width_sel;
  logic       rx_in;
  logic       rx_out;
  modport ctl  (output enable, output width_sel, output rx_in, input rx_out);
  modport filt (input enable, input width_sel, input rx_in, output rx_out);
endinterface
`default_nettype wire

// [verilog/lufc_noise_filter.sv]
/*
 * Receive noise filter: saturating up/down counter of selectable width.
 * Assumes rx_in is synchronous and reset is synchronous, active high.
 */
`timescale 1ns/1ps
`default_nettype none
module lufc_noise_filter (
  input  wire logic   clk,
  input  wire logic   reset,
  lufc_filt_if.filt   f
);
  localparam int W = lufc_pkg::FILT_MAX_W;
  logic [W-1:0] cnt_q;
  logic [W-1:0] max_w;
  logic         out_q;

  always_comb max_w = {W{1'b1}} >> (3'h7 - f.width_sel);

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (!f.enable) begin
      // preload so enabling the filter causes no glitch
      cnt_q <= f.rx_in ? max_w : '0;
    end else if (cnt_q > max_w) begin
      cnt_q <= max_w;
    end else if (f.rx_in && cnt_q != max_w) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (!f.rx_in && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      out_q <= 1'b1;
    end else if (!f.enable) begin
      out_q <= f.rx_in;
    end else if (f.rx_in && cnt_q == max_w - 1'b1) begin
      out_q <= 1'b1;
    end else if (!f.rx_in && cnt_q == {{(W-1){1'b0}}, 1'b1}) begin
      out_q <= 1'b0;
    end
  end
  assign f.rx_out = out_q;

  property p_bypass;
    @(posedge clk) disable iff (reset) !f.enable |=> (f.rx_out == $past(f.rx_in));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass path does not follow input");

  property p_rise_at_full;
    @(posedge clk) disable iff (reset)
      $past(f.enable) && f.enable && $rose(f.rx_out) |-> cnt_q == max_w;
  endproperty
  a_rise_at_full: assert property (p_rise_at_full) else $error("output rose before full");

  property p_cap;
    @(posedge clk) disable iff (reset)
      $past(f.enable) && $stable(f.width_sel) |-> cnt_q <= max_w;
  endproperty
  a_cap: assert property (p_cap) else $error("counter beyond selected width");

  c_filter_rise: cover property (@(posedge clk) disable iff (reset) f.enable && $rose(f.rx_out));
endmodule
`default_nettype wire

// [verilog/lufc_top.sv]
/*
 * Serial channel control-one window: APB slave, mode-selected filter and
 * bus node registers, slave break/rate detection, master break send, interrupt.
 * Assumes a 40 MHz CLK, synchronous active-high RESET, and RXD from a pin.
 */
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module lufc_top #(
  parameter int BIT_CYC = lufc_pkg::BIT_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [13:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RXD,
  output logic             RXD_FILT,
  output logic             TXD,
  output logic             IRQ,
  output logic             MASTER_ACTIVE,
  output logic             SLAVE_ACTIVE,
  output logic      [1:0]  NODE_STATE
);
  logic [2:0]  mode_select_field_q;
  logic [2:0]  cfg_q;
  logic [7:0]  filt_q;
  logic [7:0]  node_q;
  logic [2:0]  stat_q;
  logic [2:0]  mask_q;
  logic [15:0] rate_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic [2:0]  rx_sync_q;
  logic        rx_q;
  logic        rxf_prev_q;
  logic        txd_q;
  logic        irq_q;
  logic        mst_q;
  logic        slv_q;

  logic [11:0] idx;
  logic        access;
  logic        wr_fire;
  logic        mapped;
  logic        wr_ctl1;
  logic [31:0] rd_val;
  logic        mst_ok;
  logic        slv_ok;
  logic        rde_eff;
  logic        rx_f;
  logic        rx_fall;
  logic        brk_end;
  logic        rate_done;
  logic        brk_sent;
  logic [2:0]  stat_set;

  lufc_filt_if fif ();
  lufc_noise_filter lufc_noise_filter_inst (
    .clk   (CLK),
    .reset (RESET),
    .f     (fif.filt)
  );

  // pin synchroniser; the change counts once stages two and three agree
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rx_sync_q <= 3'h7;
      rx_q      <= 1'b1;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], RXD};
      if (rx_sync_q[1] == rx_sync_q[2]) begin
        rx_q <= rx_sync_q[2];
      end
    end
  end

  assign fif.enable    = filt_q[lufc_pkg::FILT_EN_BIT];
  assign fif.width_sel = filt_q[lufc_pkg::FILT_W_LSB +: 3];
  assign fif.rx_in     = rx_q;
  assign rx_f          = fif.rx_out;

  // APB decode; one wait state, answer from flops
  always_comb begin
    idx     = PADDR[13:2];
    access  = PSEL && PENABLE;
    wr_fire = access && pready_q && PWRITE;
    mapped  = (idx == lufc_pkg::IDX_MODE) || (idx == lufc_pkg::IDX_CFG)
           || (idx == lufc_pkg::IDX_CTL1) || (idx == lufc_pkg::IDX_STAT)
           || (idx == lufc_pkg::IDX_MASK) || (idx == lufc_pkg::IDX_RATE);
    wr_ctl1 = wr_fire && idx == lufc_pkg::IDX_CTL1;
    rd_val  = 32'h0;
    case (idx)
      lufc_pkg::IDX_MODE: rd_val = {29'h0, mode_select_field_q};
      lufc_pkg::IDX_CFG:  rd_val = {30'h0, cfg_q[1:0]};
      lufc_pkg::IDX_CTL1: begin
        if (mode_select_field_q == lufc_pkg::MODE_SELECT_FIELD_FILTER) begin
          rd_val = {24'h0, filt_q};
        end else if (mode_select_field_q == lufc_pkg::MODE_SELECT_FIELD_NODE) begin
          rd_val = {24'h0, node_q};
        end
      end
      lufc_pkg::IDX_STAT: rd_val = {29'h0, stat_q};
      lufc_pkg::IDX_MASK: rd_val = {29'h0, mask_q};
      lufc_pkg::IDX_RATE: rd_val = {16'h0, rate_q};
      default:            rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= access && !pready_q;
      pslverr_q <= access && !pready_q && !mapped;
      if (access && !pready_q && !PWRITE) begin
        prdata_q <= rd_val;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      mode_select_field_q <= 3'h0;
      cfg_q  <= 3'h0;
      mask_q <= 3'h0;
    end else begin
      cfg_q[lufc_pkg::CFG_SENDBRK] <= 1'b0;
      if (wr_fire && idx == lufc_pkg::IDX_MODE) begin
        mode_select_field_q <= PWDATA[2:0];
      end
      if (wr_fire && idx == lufc_pkg::IDX_CFG) begin
        cfg_q <= PWDATA[2:0];
      end
      if (wr_fire && idx == lufc_pkg::IDX_MASK) begin
        mask_q <= PWDATA[2:0];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      filt_q <= lufc_pkg::CTL_RESET;
    end else if (wr_ctl1 && mode_select_field_q == lufc_pkg::MODE_SELECT_FIELD_FILTER) begin
      filt_q <= {PWDATA[7:4], 4'h0};
    end
  end

  always_comb begin
    mst_ok  = node_q[lufc_pkg::MST_BIT] && !node_q[lufc_pkg::SLV_BIT]
           && !cfg_q[lufc_pkg::CFG_MULTIPROCESSOR_ENABLE] && !cfg_q[lufc_pkg::CFG_PEN];
    slv_ok  = node_q[lufc_pkg::SLV_BIT] && !node_q[lufc_pkg::MST_BIT]
           && !cfg_q[lufc_pkg::CFG_MULTIPROCESSOR_ENABLE] && !cfg_q[lufc_pkg::CFG_PEN];
    rde_eff = slv_ok && node_q[lufc_pkg::RDE_BIT];
  end

  // bit-time enable and break/sync measurement
  logic [15:0] bit_cnt_q;
  logic        bit_tick_q;
  logic [3:0]  low_bits_q;
  logic [2:0]  falls_q;
  logic [15:0] meas_q;
  logic [4:0]  brk_left_q;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      bit_cnt_q  <= 16'h0;
      bit_tick_q <= 1'b0;
    end else begin
      bit_tick_q <= (bit_cnt_q == 16'(BIT_CYC - 1));
      bit_cnt_q  <= (bit_cnt_q == 16'(BIT_CYC - 1)) ? 16'h0 : bit_cnt_q + 16'h1;
    end
  end

  always_comb begin
    rx_fall   = rxf_prev_q && !rx_f;
    brk_end   = !rxf_prev_q && rx_f && low_bits_q >= 4'(lufc_pkg::RX_BREAK_BITS);
    rate_done = rx_fall && NODE_STATE == lufc_pkg::NODE_RATE
             && falls_q == 3'(lufc_pkg::SYNC_FALLS - 1);
    brk_sent  = brk_left_q == 5'h1 && bit_tick_q;
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rxf_prev_q <= 1'b1;
      low_bits_q <= 4'h0;
    end else begin
      rxf_prev_q <= rx_f;
      if (rx_f) begin
        low_bits_q <= 4'h0;
      end else if (bit_tick_q && low_bits_q != 4'hF) begin
        low_bits_q <= low_bits_q + 4'h1;
      end
    end
  end

  // sync character: first to fifth falling edge spans eight bit times
  always_ff @(posedge CLK) begin
    if (RESET) begin
      falls_q <= 3'h0;
      meas_q  <= 16'h0;
      rate_q  <= 16'h0;
    end else if (NODE_STATE != lufc_pkg::NODE_RATE) begin
      falls_q <= 3'h0;
      meas_q  <= 16'h0;
    end else begin
      if (falls_q != 3'h0 && meas_q != 16'hFFFF) begin
        meas_q <= meas_q + 16'h1;
      end
      if (rx_fall) begin
        falls_q <= falls_q + 3'h1;
      end
      if (rate_done) begin
        rate_q <= meas_q;
      end
    end
  end

  // node state, software write wins over hardware advance
  always_ff @(posedge CLK) begin
    if (RESET) begin
      node_q <= lufc_pkg::CTL_RESET;
    end else if (wr_ctl1 && mode_select_field_q == lufc_pkg::MODE_SELECT_FIELD_NODE) begin
      node_q <= PWDATA[7:0];
    end else if (slv_ok) begin
      case (lufc_pkg::lufc_node_e'(node_q[lufc_pkg::STATE_LSB +: 2]))
        lufc_pkg::NODE_WAIT_BRK: begin
          if (brk_end) begin
            node_q[lufc_pkg::STATE_LSB +: 2] <= rde_eff ? lufc_pkg::NODE_RATE
                                                        : lufc_pkg::NODE_ACTIVE;
          end
        end
        lufc_pkg::NODE_RATE: begin
          if (rate_done || !rde_eff) begin
            node_q[lufc_pkg::STATE_LSB +: 2] <= lufc_pkg::NODE_ACTIVE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // master break of 13 + code bit times
  always_ff @(posedge CLK) begin
    if (RESET) begin
      brk_left_q <= 5'h0;
      txd_q      <= 1'b1;
    end else begin
      if (cfg_q[lufc_pkg::CFG_SENDBRK] && mst_ok && brk_left_q == 5'h0) begin
        brk_left_q <= 5'(lufc_pkg::TX_BREAK_BASE) + {3'h0, node_q[1:0]};
      end else if (bit_tick_q && brk_left_q != 5'h0) begin
        brk_left_q <= brk_left_q - 5'h1;
      end
      txd_q <= !(brk_left_q != 5'h0 && !brk_sent);
    end
  end

  // done flag only with its enable in slave mode
  always_comb begin
    stat_set = 3'h0;
    stat_set[lufc_pkg::ST_RATE_DONE] = rate_done && rde_eff && node_q[lufc_pkg::RDIE_BIT];
    stat_set[lufc_pkg::ST_BRK_RX]    = brk_end && slv_ok;
    stat_set[lufc_pkg::ST_BRK_TX]    = brk_sent;
  end

  // write one to clear; a same-cycle event wins
  always_ff @(posedge CLK) begin
    if (RESET) begin
      stat_q <= lufc_pkg::STAT_RESET;
    end else begin
      stat_q <= (stat_q & ~((wr_fire && idx == lufc_pkg::IDX_STAT) ? PWDATA[2:0] : 3'h0))
              | stat_set;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      irq_q <= 1'b0;
      mst_q <= 1'b0;
      slv_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
      mst_q <= mst_ok;
      slv_q <= slv_ok;
    end
  end

  assign PRDATA        = prdata_q;
  assign PREADY        = pready_q;
  assign PSLVERR       = pslverr_q;
  assign RXD_FILT      = rx_f;
  assign TXD           = txd_q;
  assign IRQ           = irq_q;
  assign MASTER_ACTIVE = mst_q;
  assign SLAVE_ACTIVE  = slv_q;
  assign NODE_STATE    = node_q[lufc_pkg::STATE_LSB +: 2];

  // helper: length of the last low stretch on TXD
  logic [19:0] txd_low_q;
  always_ff @(posedge CLK) begin
    if (RESET || TXD) begin
      txd_low_q <= 20'h0;
    end else if (txd_low_q != 20'hFFFFF) begin
      txd_low_q <= txd_low_q + 20'h1;
    end
  end

  property p_filt_route;
    @(posedge CLK) disable iff (RESET)
      wr_ctl1 && mode_select_field_q == lufc_pkg::MODE_SELECT_FIELD_FILTER
      |=> filt_q == {$past(PWDATA[7:4]), 4'h0};
  endproperty
  a_filt_route: assert property (p_filt_route) else $error("filter window write lost");

  property p_node_route;
    @(posedge CLK) disable iff (RESET)
      wr_ctl1 && mode_select_field_q == lufc_pkg::MODE_SELECT_FIELD_NODE |=> node_q == $past(PWDATA[7:0]) && $stable(filt_q);
  endproperty
  a_node_route: assert property (p_node_route) else $error("node window write misrouted");

  property p_master_excl;
    @(posedge CLK) disable iff (RESET)
      $past(node_q[lufc_pkg::SLV_BIT]) || $past(cfg_q[1:0]) != 2'h0 |-> !MASTER_ACTIVE;
  endproperty
  a_master_excl: assert property (p_master_excl) else $error("master despite conflict");

  property p_slave_excl;
    @(posedge CLK) disable iff (RESET)
      $past(node_q[lufc_pkg::MST_BIT]) || $past(cfg_q[1:0]) != 2'h0 |-> !SLAVE_ACTIVE;
  endproperty
  a_slave_excl: assert property (p_slave_excl) else $error("slave despite conflict");

  property p_rate_gate;
    @(posedge CLK) disable iff (RESET)
      $rose(stat_q[lufc_pkg::ST_RATE_DONE]) |-> $past(rde_eff && node_q[lufc_pkg::RDIE_BIT]);
  endproperty
  a_rate_gate: assert property (p_rate_gate) else $error("done flag without enable");

  property p_rate_state;
    @(posedge CLK) disable iff (RESET)
      !$past(wr_ctl1) && $past(NODE_STATE) == lufc_pkg::NODE_WAIT_BRK
      && NODE_STATE == lufc_pkg::NODE_RATE |-> $past(rde_eff);
  endproperty
  a_rate_state: assert property (p_rate_state) else $error("measurement without enable");

  property p_irq;
    @(posedge CLK) disable iff (RESET) |(stat_q & mask_q) |=> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked status without interrupt");

  property p_brk_len;
    @(posedge CLK) disable iff (RESET)
      $rose(TXD) |-> $past(txd_low_q) >= 20'(12 * BIT_CYC - 1);
  endproperty
  a_brk_len: assert property (p_brk_len) else $error("transmitted break too short");

  c_rate_done: cover property (@(posedge CLK) disable iff (RESET) rate_done && rde_eff);
  c_brk_sent:  cover property (@(posedge CLK) disable iff (RESET) brk_sent);
  c_err:       cover property (@(posedge CLK) disable iff (RESET) PSLVERR && PREADY);
endmodule
`default_nettype wire

// [verification/lufc_bus_node.sv]
/*
 * Bus node model on the receive line: idles recessive high, sends a break,
 * its delimiter and characters, one bit every PB clocks.
 * Assumes callers enter its tasks just after a rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module lufc_bus_node #(
  parameter int PB = 16
) (
  input  wire logic clk,
  output logic      line
);
  // recessive level under the bus pull-up
  initial line = 1'b1;

  task automatic hold(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge clk);
  endtask

  task automatic send_break(input int bits);
    hold(1'b0, bits * PB);
    hold(1'b1, PB);
  endtask

  task automatic send_byte(input logic [7:0] b);
    hold(1'b0, PB);
    for (int i = 0; i < 8; i++) begin
      hold(b[i], PB);
    end
    hold(1'b1, PB);
  endtask
endmodule
`default_nettype wire

// [verification/lufc_tb_top.sv]
/*
 * Self-checking bench: APB register tasks, filter delay and glitch checks,
 * master qualification and break, slave break and rate detect with interrupt.
 * Assumes lufc_top with a short bit time and a bus node model on RXD.
 */
`timescale 1ns/1ps
`default_nettype none
module lufc_tb_top;
  localparam int BC = 8;
  localparam int PB = 16;
  localparam logic [11:0] MODE = lufc_pkg::IDX_MODE;
  localparam logic [11:0] CFG  = lufc_pkg::IDX_CFG;
  localparam logic [11:0] CTL  = lufc_pkg::IDX_CTL1;
  localparam logic [11:0] STAT = lufc_pkg::IDX_STAT;
  localparam logic [11:0] MASK = lufc_pkg::IDX_MASK;
  localparam logic [11:0] RATE = lufc_pkg::IDX_RATE;
  // config, control, master, slave
  localparam logic [17:0] MT [6] = '{{8'h00, 8'h80, 2'b10}, {8'h02, 8'h80, 2'b00},
    {8'h01, 8'h80, 2'b00}, {8'h00, 8'hC0, 2'b00}, {8'h00, 8'h40, 2'b01},
    {8'h01, 8'h40, 2'b00}};
  // control, state after break, final state, status, irq
  localparam logic [15:0] ST [4] = '{{8'h74, 2'h2, 2'h3, 3'h3, 1'b1},
    {8'h64, 2'h2, 2'h3, 3'h2, 1'b0}, {8'h44, 2'h3, 2'h3, 3'h2, 1'b0},
    {8'hA4, 2'h1, 2'h1, 3'h0, 1'b0}};

  logic        clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [13:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        rxd;
  logic        rxd_filt;
  logic        txd;
  logic        irq;
  logic        mst;
  logic        slv;
  logic [1:0]  node_state;
  int          err_total;
  int          tests_run;
  int          b;
  int          d;
  int          lows;

  lufc_top #(.BIT_CYC(BC)) lufc_top_inst (.CLK(clk), .RESET(reset), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RXD(rxd), .RXD_FILT(rxd_filt), .TXD(txd),
    .IRQ(irq), .MASTER_ACTIVE(mst), .SLAVE_ACTIVE(slv), .NODE_STATE(node_state));
  lufc_bus_node #(.PB(PB)) lufc_bus_node_inst (.clk(clk), .line(rxd));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one transfer; an idle edge follows so the next setup never collides
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle limit here: only the watchdog ends a stuck wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] v);
    apb(1'b1, idx, v);
  endtask

  task automatic rdc(input logic [11:0] idx, input logic [31:0] exp, input string name);
    apb(1'b0, idx, 32'h0);
    check(name, rd, exp);
  endtask

  task automatic step(input logic v, output int n);
    lufc_bus_node_inst.hold(v, 1);
    n = 1;
    while (rxd_filt !== v && n < 5000) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic glitch(output int n);
    n = 0;
    fork
      begin
        lufc_bus_node_inst.hold(1'b0, 10);
        lufc_bus_node_inst.hold(1'b1, 1);
      end
      repeat (40) begin
        @(posedge clk);
        if (rxd_filt !== 1'b1) n++;
      end
    join
  endtask

  initial begin
    #2000000;
    err_total++;
    summarize();
  end

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0;
    pwdata = 32'h0;
    err_total = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    check("tx idle", {31'h0, txd}, 32'h1);
    check("rx idle", {31'h0, rxd_filt}, 32'h1);
    check("state rst", {30'h0, node_state}, 32'h0);
    wr(MODE, 32'h1);
    rdc(CTL, 32'h0, "filter rst");
    wr(MODE, 32'h2);
    rdc(CTL, 32'h0, "node rst");
    wr(CTL, 32'hA3);
    rdc(CTL, 32'hA3, "node rw");
    wr(MODE, 32'h1);
    rdc(CTL, 32'h0, "filter window");
    wr(MODE, 32'h3);
    rdc(CTL, 32'h0, "closed window");
    apb(1'b0, 12'hF42, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    wr(MODE, 32'h2);
    wr(CTL, 32'h0);
    wr(MODE, 32'h1);
    step(1'b0, b);
    step(1'b1, d);
    check("bypass rise", d, b);
    for (int w = 0; w < 8; w++) begin
      // preload at the new width before enabling
      wr(CTL, {25'h0, w[2:0], 4'h0});
      wr(CTL, {24'h0, 1'b1, w[2:0], 4'h0});
      rdc(CTL, {24'h0, 1'b1, w[2:0], 4'h0}, "filter cfg");
      step(1'b0, d);
      // output flips on the edge the counter hits its end: full scale minus one extra
      check("filt fall", d, b + (1 << (w + 4)) - 2);
      step(1'b1, d);
      check("filt rise", d, b + (1 << (w + 4)) - 2);
    end
    wr(CTL, 32'h0);
    wr(CTL, 32'h80);
    glitch(lows);
    check("glitch filtered", lows, 0);
    wr(CTL, 32'h0);
    glitch(lows);
    check("glitch bypass", lows, 10);
    wr(MODE, 32'h2);
    for (int i = 0; i < 6; i++) begin
      wr(CFG, {24'h0, MT[i][17:10]});
      wr(CTL, {24'h0, MT[i][9:2]});
      repeat (2) @(posedge clk);
      check("master act", {31'h0, mst}, {31'h0, MT[i][1]});
      check("slave act", {31'h0, slv}, {31'h0, MT[i][0]});
    end
    wr(CFG, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wr(CTL, 32'h8C | c);
      d = 0;
      fork
        wr(CFG, 32'h4);
        begin
          repeat (20) if (txd !== 1'b0) @(posedge clk);
          while (txd === 1'b0 && d < 5000) begin
            @(posedge clk);
            d++;
          end
        end
      join
      check("break len", d >= (12 + c) * BC && d <= (13 + c) * BC, 32'h1);
      rdc(STAT, 32'h4, "break sent");
    end
    wr(CTL, 32'h0);
    wr(MASK, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(STAT, 32'h7);
      repeat (2) @(posedge clk);
      check("irq clear", {31'h0, irq}, 32'h0);
      wr(CTL, {24'h0, ST[i][15:8]});
      lufc_bus_node_inst.send_break(13);
      check("state mid", {30'h0, node_state}, {30'h0, ST[i][7:6]});
      lufc_bus_node_inst.send_byte(8'h55);
      repeat (10) @(posedge clk);
      check("state end", {30'h0, node_state}, {30'h0, ST[i][5:4]});
      check("irq", {31'h0, irq}, {31'h0, ST[i][0]});
      rdc(STAT, {29'h0, ST[i][3:1]}, "status");
      // capture takes the count standing just before the fifth falling edge
      if (i == 0) rdc(RATE, 8 * PB - 1, "rate");
    end
    summarize();
  end
endmodule
`default_nettype wire
